//--- core/cscc_regs.sv
/*
 cscc_regs: cpu status and core control register bank with apb slave.
 assumes: the instruction pipeline drives flag updates and loop events
 on core_clk_in; the interrupt controller reads the effective priority.
 assumes: flag updates and loop enter/exit are one-cycle pulses and repeat_busy a level, all from the same clock,
 so they pass no synchroniser; the apb master runs on core_clk_in too.
 unmapped words answer with pslverr and read as zero.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module cscc_regs
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire cscc_pkg::cscc_apb_s apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire cscc_pkg::cscc_flags_s flags_in,
    input wire cscc_pkg::cscc_loop_s loop_in,
    input wire logic prio_load_in,
    input wire logic [3:0] prio_load_val_in,
    output logic [3:0] cpu_level_out,
    output logic user_irq_block_out,
    output logic multiply_sign_select_out,
    output logic early_loop_exit_out,
    output logic [2:0] loop_nest_depth_out
);
    import cscc_pkg::*;

    // =========================================================
    // state
    logic [2:0] cpu_priority_field_reg;
    logic priority_high_bit_reg;
    logic repeat_active_reg;
    logic neg_reg, ovf_reg, zero_reg, carry_reg;
    logic multiply_sign_select_reg;
    logic early_loop_exit_reg;
    logic [2:0] loop_nest_depth_reg;
    logic nesting_disable_reg;
    logic [31:0] prdata_reg;

    // =========================================================
    // bus decode
    // the access phase is psel with penable; writes land at its edge
    wire access_w = apb_in.psel & apb_in.penable;
    wire wr_w = access_w & apb_in.pwrite;
    wire rd_w = access_w & ~apb_in.pwrite;
    wire hit_st_w = apb_in.paddr == CSCC_ADDR_STATUS;
    wire hit_cc_w = apb_in.paddr == CSCC_ADDR_CONTROL;
    wire hit_ic_w = apb_in.paddr == CSCC_ADDR_INTCTL;
    wire mapped_w = hit_st_w | hit_cc_w | hit_ic_w;
    wire wr_st_w = wr_w & hit_st_w;
    wire wr_cc_w = wr_w & hit_cc_w;
    wire wr_ic_w = wr_w & hit_ic_w;

    // zero-wait answer, error on unmapped
    assign pready_out = 1'b1;
    assign pslverr_out = access_w & ~mapped_w;

    // =========================================================
    // register images
    wire [31:0] status_img_w = {16'h0000, 8'h00,
        cpu_priority_field_reg, repeat_active_reg,
        neg_reg, ovf_reg, zero_reg, carry_reg};
    // bit 11 reads back an early exit request that is still pending
    wire [31:0] control_img_w = {16'h0000, 3'h0,
        multiply_sign_select_reg,
        early_loop_exit_reg,
        loop_nest_depth_reg,
        4'h0, priority_high_bit_reg, 3'h0};
    wire [31:0] intctl_img_w = {16'h0000, nesting_disable_reg, 15'h0000};
    wire [31:0] rd_mux_w = hit_st_w ? status_img_w :
                           hit_cc_w ? control_img_w :
                           hit_ic_w ? intctl_img_w : CSCC_RDATA_ZERO;

    // read data register, set up in the setup phase
    // loading in setup keeps prdata a flip-flop and the answer zero-wait
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            prdata_reg <= CSCC_RDATA_ZERO;
        else if (apb_in.psel & ~apb_in.penable & ~apb_in.pwrite)
            prdata_reg <= rd_mux_w;
    end
    assign prdata_out = prdata_reg;

    // =========================================================
    // priority field: software write unless nesting disabled; the high bit in core control is always writable
    // a hardware load (interrupt entry or return) wins and ignores the lock
    wire prio_sw_w = wr_st_w & ~nesting_disable_reg;
    wire [2:0] prio_next = prio_load_in ? prio_load_val_in[2:0] :
        prio_sw_w ? apb_in.pwdata[CSCC_ST_PRIO_HI:CSCC_ST_PRIO_LO] :
        cpu_priority_field_reg;
    wire high_next = prio_load_in ? prio_load_val_in[3] :
        wr_cc_w ? apb_in.pwdata[CSCC_CC_PRIO_HIGH] : priority_high_bit_reg;

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cpu_priority_field_reg <= CSCC_PRIO_RESET;
            priority_high_bit_reg <= 1'b0;
            nesting_disable_reg <= 1'b0;
        end
        else
        begin
            cpu_priority_field_reg <= prio_next;
            priority_high_bit_reg <= high_next;
            if (wr_ic_w)
                nesting_disable_reg <= apb_in.pwdata[CSCC_IC_NESTDIS];
        end
    end

    // effective level and user interrupt gate
    assign cpu_level_out = {priority_high_bit_reg, cpu_priority_field_reg};
    assign user_irq_block_out = priority_high_bit_reg
        | (cpu_priority_field_reg == CSCC_PRIO_MAX);

    // =========================================================
    // arithmetic flags; pipeline update wins over software write
    // the pipeline can only clear zero, never set it; a zero result leaves it sticky
    wire neg_next = flags_in.upd_n ? flags_in.neg :
        wr_st_w ? apb_in.pwdata[CSCC_ST_NEG] : neg_reg;
    wire ovf_next = flags_in.upd_ov ? flags_in.ovf :
        wr_st_w ? apb_in.pwdata[CSCC_ST_OVF] : ovf_reg;
    wire zero_next = flags_in.upd_z ? (zero_reg & ~flags_in.nonzero) :
        wr_st_w ? apb_in.pwdata[CSCC_ST_ZERO] : zero_reg;
    wire carry_next = flags_in.upd_c ? flags_in.carry :
        wr_st_w ? apb_in.pwdata[CSCC_ST_CARRY] : carry_reg;

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            neg_reg <= 1'b0;
            ovf_reg <= 1'b0;
            zero_reg <= 1'b0;
            carry_reg <= 1'b0;
            repeat_active_reg <= 1'b0;
        end
        else
        begin
            neg_reg <= neg_next;
            ovf_reg <= ovf_next;
            zero_reg <= zero_next;
            carry_reg <= carry_next;
            repeat_active_reg <= loop_in.repeat_busy;
        end
    end

    // =========================================================
    // core control: sign select, early exit, loop depth
    // the nest counter saturates at both ends; enter with exit cancels
    wire early_set_w = wr_cc_w & apb_in.pwdata[CSCC_CC_EARLY];
    wire depth_up_w = loop_in.loop_enter & ~loop_in.loop_exit
        & (loop_nest_depth_reg != CSCC_DEPTH_MAX);
    wire depth_dn_w = loop_in.loop_exit & ~loop_in.loop_enter
        & (loop_nest_depth_reg != CSCC_DEPTH_RESET);
    wire [2:0] depth_next = depth_up_w ? loop_nest_depth_reg + 3'h1 :
        depth_dn_w ? loop_nest_depth_reg - 3'h1 : loop_nest_depth_reg;
    // request holds until the loop retires; a new write wins over the clear
    wire early_next = early_set_w | (early_loop_exit_reg & ~loop_in.loop_exit);

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            multiply_sign_select_reg <= 1'b0;
            early_loop_exit_reg <= 1'b0;
            loop_nest_depth_reg <= CSCC_DEPTH_RESET;
        end
        else
        begin
            if (wr_cc_w)
                multiply_sign_select_reg <= apb_in.pwdata[CSCC_CC_MULSIGN];
            early_loop_exit_reg <= early_next;
            loop_nest_depth_reg <= depth_next;
        end
    end

    // control outputs come straight from their flip-flops
    assign multiply_sign_select_out = multiply_sign_select_reg;
    assign early_loop_exit_out = early_loop_exit_reg;
    assign loop_nest_depth_out = loop_nest_depth_reg;

    // =========================================================
    // checks: priority field and user interrupt gate
    a_prio_locked: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (nesting_disable_reg && !prio_load_in) |=> $stable(cpu_priority_field_reg))
        else $error("priority field changed while locked");
    a_prio_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (prio_sw_w && !prio_load_in)
        |=> cpu_priority_field_reg == $past(apb_in.pwdata[CSCC_ST_PRIO_HI:CSCC_ST_PRIO_LO]))
        else $error("priority field not written");
    a_lock_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        wr_ic_w |=> nesting_disable_reg == $past(apb_in.pwdata[CSCC_IC_NESTDIS]))
        else $error("nesting disable not written");
    a_level_join: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        prio_load_in |=> cpu_level_out == $past(prio_load_val_in))
        else $error("effective level not loaded");
    a_high_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (wr_cc_w && !prio_load_in) |=> priority_high_bit_reg == $past(apb_in.pwdata[CSCC_CC_PRIO_HIGH]))
        else $error("high priority bit not written");
    a_high_blocks: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        priority_high_bit_reg |-> user_irq_block_out)
        else $error("high bit did not block");
    a_seven_blocks: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cpu_priority_field_reg == CSCC_PRIO_MAX) |-> user_irq_block_out)
        else $error("level 7 did not block");
    a_low_open: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!priority_high_bit_reg && cpu_priority_field_reg != CSCC_PRIO_MAX) |-> !user_irq_block_out)
        else $error("block without cause");

    // checks: repeat bit and arithmetic flags
    a_repeat_follow: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        loop_in.repeat_busy |=> repeat_active_reg)
        else $error("repeat bit not set");
    a_repeat_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !loop_in.repeat_busy |=> !repeat_active_reg)
        else $error("repeat bit not cleared");
    a_neg_update: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        flags_in.upd_n |=> neg_reg == $past(flags_in.neg))
        else $error("negative flag wrong");
    a_ovf_update: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        flags_in.upd_ov |=> ovf_reg == $past(flags_in.ovf))
        else $error("overflow flag wrong");
    a_zero_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (flags_in.upd_z && flags_in.nonzero) |=> !zero_reg)
        else $error("zero flag not cleared");
    a_zero_sticky: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (flags_in.upd_z && !flags_in.nonzero && !wr_st_w) |=> $stable(zero_reg))
        else $error("zero flag moved on zero result");
    a_carry_update: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        flags_in.upd_c |=> carry_reg == $past(flags_in.carry))
        else $error("carry flag wrong");
    a_flags_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!flags_in.upd_c && !wr_st_w) |=> $stable(carry_reg))
        else $error("carry changed without cause");
    a_neg_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!flags_in.upd_n && !wr_st_w) |=> $stable(neg_reg))
        else $error("negative changed without cause");
    a_ovf_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!flags_in.upd_ov && !wr_st_w) |=> $stable(ovf_reg))
        else $error("overflow changed without cause");
    a_zero_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!flags_in.upd_z && !wr_st_w) |=> $stable(zero_reg))
        else $error("zero changed without cause");
    a_neg_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (wr_st_w && !flags_in.upd_n) |=> neg_reg == $past(apb_in.pwdata[CSCC_ST_NEG]))
        else $error("negative flag not written");
    a_carry_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (wr_st_w && !flags_in.upd_c) |=> carry_reg == $past(apb_in.pwdata[CSCC_ST_CARRY]))
        else $error("carry flag not written");

    // checks: core control and loop nesting depth
    a_sign_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        wr_cc_w |=> multiply_sign_select_reg == $past(apb_in.pwdata[CSCC_CC_MULSIGN]))
        else $error("sign select not written");
    a_sign_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !wr_cc_w |=> $stable(multiply_sign_select_reg))
        else $error("sign select changed without write");
    a_early_set: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        early_set_w |=> early_loop_exit_out)
        else $error("early exit not raised");
    a_early_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (loop_in.loop_exit && !early_set_w) |=> !early_loop_exit_reg)
        else $error("early exit not retired");
    a_early_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!early_set_w && !loop_in.loop_exit) |=> $stable(early_loop_exit_reg))
        else $error("early exit changed without cause");
    a_depth_step: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (loop_in.loop_enter && !loop_in.loop_exit && loop_nest_depth_reg != CSCC_DEPTH_MAX)
        |=> loop_nest_depth_reg == $past(loop_nest_depth_reg) + 3'h1)
        else $error("depth did not count up");
    a_depth_down: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (loop_in.loop_exit && !loop_in.loop_enter && loop_nest_depth_reg != CSCC_DEPTH_RESET)
        |=> loop_nest_depth_reg == $past(loop_nest_depth_reg) - 3'h1)
        else $error("depth did not count down");
    a_depth_top: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (loop_in.loop_enter && loop_nest_depth_reg == CSCC_DEPTH_MAX) |=> loop_nest_depth_reg == CSCC_DEPTH_MAX)
        else $error("depth wrapped past full");
    a_depth_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (loop_in.loop_enter == loop_in.loop_exit) |=> $stable(loop_nest_depth_reg))
        else $error("depth changed without cause");

    // covers for the main scenarios
    c_locked_write: cover property (@(posedge core_clk_in) wr_st_w && nesting_disable_reg);
    c_level_high: cover property (@(posedge core_clk_in) cpu_level_out == 4'hf);
    c_depth_full: cover property (@(posedge core_clk_in) loop_nest_depth_reg == 3'h7);
    c_early_exit: cover property (@(posedge core_clk_in) early_loop_exit_reg && loop_in.loop_exit);
    c_zero_sticky: cover property (@(posedge core_clk_in) flags_in.upd_z && !flags_in.nonzero && zero_reg);

endmodule : cscc_regs

//--- core/cscc_pkg.sv
/*
 cscc_pkg: shared constants, struct types and register layout for the
 cpu status / core control register bank.
 assumes: apb slave with 32-bit data, one aligned word per register.
*/
package cscc_pkg;

    // =========================================================
    // register map (byte addresses)
    localparam logic [7:0] CSCC_ADDR_STATUS = 8'h00;
    localparam logic [7:0] CSCC_ADDR_CONTROL = 8'h04;
    localparam logic [7:0] CSCC_ADDR_INTCTL = 8'h08;

    // =========================================================
    // cpu_status field positions
    localparam int CSCC_ST_PRIO_HI = 7;
    localparam int CSCC_ST_PRIO_LO = 5;
    localparam int CSCC_ST_REPEAT = 4;
    localparam int CSCC_ST_NEG = 3;
    localparam int CSCC_ST_OVF = 2;
    localparam int CSCC_ST_ZERO = 1;
    localparam int CSCC_ST_CARRY = 0;

    // =========================================================
    // core_control field positions
    localparam int CSCC_CC_MULSIGN = 12;
    localparam int CSCC_CC_EARLY = 11;
    localparam int CSCC_CC_DEPTH_HI = 10;
    localparam int CSCC_CC_DEPTH_LO = 8;
    localparam int CSCC_CC_PRIO_HIGH = 3;

    // interrupt_control_one nesting disable bit
    localparam int CSCC_IC_NESTDIS = 15;

    // =========================================================
    // reset values and level constants
    localparam logic [2:0] CSCC_PRIO_RESET = 3'h0;
    localparam logic [2:0] CSCC_PRIO_MAX = 3'h7;
    localparam logic [2:0] CSCC_DEPTH_RESET = 3'h0;
    localparam logic [2:0] CSCC_DEPTH_MAX = 3'h7;
    localparam logic [31:0] CSCC_RDATA_ZERO = 32'h0000_0000;

    // =========================================================
    // arithmetic flag update from the pipeline
    typedef struct packed {
        logic upd_n;
        logic upd_ov;
        logic upd_z;
        logic upd_c;
        logic neg;
        logic ovf;
        logic nonzero;
        logic carry;
    } cscc_flags_s;

    // loop events from the pipeline
    typedef struct packed {
        logic repeat_busy;
        logic loop_enter;
        logic loop_exit;
    } cscc_loop_s;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cscc_apb_s;

endpackage : cscc_pkg

//--- sim/tb_cscc_regs.sv
/*
 tb_cscc_regs: self-checking bench for the status / control register bank.
 assumes: cscc_pkg and cscc_regs compiled first; apb slave answers by pready.
*/
`timescale 1ns/1ns
module tb_cscc_regs;
    import cscc_pkg::*;
    // =========================================================
    // stimulus and observation
    logic core_clk_in;
    logic rstn_in;
    cscc_apb_s apb_r;
    cscc_flags_s flags_r;
    cscc_loop_s loop_r;
    logic prio_load_r;
    logic [3:0] prio_val_r;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [3:0] cpu_level_out;
    logic user_irq_block_out;
    logic multiply_sign_select_out;
    logic early_loop_exit_out;
    logic [2:0] loop_nest_depth_out;
    logic [31:0] rd;
    logic serr;
    int err_count;
    int num_checks;

    cscc_regs u_cscc_regs (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .apb_in(apb_r),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .flags_in(flags_r), .loop_in(loop_r), .prio_load_in(prio_load_r),
        .prio_load_val_in(prio_val_r), .cpu_level_out(cpu_level_out),
        .user_irq_block_out(user_irq_block_out), .multiply_sign_select_out(multiply_sign_select_out),
        .early_loop_exit_out(early_loop_exit_out), .loop_nest_depth_out(loop_nest_depth_out));

    // =========================================================
    // shared tasks
    task test_done;
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // compare one value, report at once
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer: setup, then access until pready at an edge
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge core_clk_in);
        apb_r.psel <= 1'b1;
        apb_r.pwrite <= wr;
        apb_r.paddr <= addr;
        apb_r.pwdata <= wdata;
        @(posedge core_clk_in);
        apb_r.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            err_count++;
            test_done();
        end
        rd = prdata_out;
        serr = pslverr_out;
        apb_r.psel <= 1'b0;
        apb_r.penable <= 1'b0;
        @(negedge core_clk_in);
    endtask : apb

    task rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk

    // one-cycle pipeline flag update, idle value keeps no update flag set
    task flag_pulse(input cscc_flags_s f);
        @(posedge core_clk_in);
        flags_r <= f;
        @(posedge core_clk_in);
        flags_r <= 8'h02;
    endtask : flag_pulse

    // n one-cycle loop events
    task loop_pulse(input cscc_loop_s l, input int n);
        repeat (n)
        begin
            @(posedge core_clk_in);
            loop_r <= l;
            @(posedge core_clk_in);
            loop_r <= '0;
        end
        @(negedge core_clk_in);
    endtask : loop_pulse

    // =========================================================
    // scenarios
    task t_reset;
        rdchk("status", CSCC_ADDR_STATUS, 32'h0);
        rdchk("control", CSCC_ADDR_CONTROL, 32'h0);
        chk("level", 32'h0, {28'h0, cpu_level_out});
    endtask : t_reset

    // every effective level, with and without the high bit
    task t_prio;
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, CSCC_ADDR_CONTROL, {28'h0, i[3], 3'h0});
            apb(1'b1, CSCC_ADDR_STATUS, {24'h0, i[2:0], 5'h0});
            chk("level", i, {28'h0, cpu_level_out});
            chk("block", {31'h0, i[3] | (i[2:0] == 3'h7)}, {31'h0, user_irq_block_out});
        end
        apb(1'b1, CSCC_ADDR_CONTROL, 32'h0);
    endtask : t_prio

    task t_lock;
        apb(1'b1, CSCC_ADDR_STATUS, 32'h40);
        apb(1'b1, CSCC_ADDR_INTCTL, 32'h8000);
        rdchk("intctl", CSCC_ADDR_INTCTL, 32'h8000);
        apb(1'b1, CSCC_ADDR_STATUS, 32'he0);
        rdchk("locked prio", CSCC_ADDR_STATUS, 32'h40);
        @(posedge core_clk_in);
        prio_load_r <= 1'b1;
        prio_val_r <= 4'h5;
        @(posedge core_clk_in);
        prio_load_r <= 1'b0;
        @(negedge core_clk_in);
        chk("loaded level", 32'h5, {28'h0, cpu_level_out});
        apb(1'b1, CSCC_ADDR_INTCTL, 32'h0);
        apb(1'b1, CSCC_ADDR_STATUS, 32'h0);
        rdchk("unlocked prio", CSCC_ADDR_STATUS, 32'h0);
    endtask : t_lock

    task t_flags;
        loop_r.repeat_busy <= 1'b1;
        flag_pulse(8'hfd);
        rdchk("flags set", CSCC_ADDR_STATUS, 32'h1d);
        apb(1'b1, CSCC_ADDR_STATUS, 32'h02);
        rdchk("idle hold", CSCC_ADDR_STATUS, 32'h12);
        flag_pulse(8'h20);
        rdchk("zero sticky", CSCC_ADDR_STATUS, 32'h12);
        flag_pulse(8'hf2);
        rdchk("flags clear", CSCC_ADDR_STATUS, 32'h10);
        loop_r.repeat_busy <= 1'b0;
        rdchk("repeat off", CSCC_ADDR_STATUS, 32'h0);
    endtask : t_flags

    task t_ctrl;
        apb(1'b1, CSCC_ADDR_CONTROL, 32'h1f00);
        rdchk("control", CSCC_ADDR_CONTROL, 32'h1800);
        chk("sign", 32'h1, {31'h0, multiply_sign_select_out});
        apb(1'b1, CSCC_ADDR_CONTROL, 32'h1000);
        chk("early kept", 32'h1, {31'h0, early_loop_exit_out});
        loop_pulse(3'b001, 1);
        chk("early", 32'h0, {31'h0, early_loop_exit_out});
        apb(1'b1, CSCC_ADDR_CONTROL, 32'h0);
        loop_pulse(3'b010, 3);
        rdchk("depth", CSCC_ADDR_CONTROL, 32'h0300);
        chk("mapped err", 32'h0, {31'h0, serr});
        loop_pulse(3'b010, 6);
        chk("depth max", 32'h7, {29'h0, loop_nest_depth_out});
        loop_pulse(3'b001, 8);
        chk("depth min", 32'h0, {29'h0, loop_nest_depth_out});
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, serr});
        chk("unmapped data", 32'h0, rd);
    endtask : t_ctrl

    // =========================================================
    // clock, reset and main sequence
    initial
    begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    initial
    begin
        rstn_in = 1'b0;
        apb_r = '0;
        flags_r = 8'h02;
        loop_r = '0;
        prio_load_r = 1'b0;
        prio_val_r = 4'h0;
        err_count = 0;
        num_checks = 0;
        repeat (12) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_prio();
        t_lock();
        t_flags();
        t_ctrl();
        test_done();
    end
endmodule : tb_cscc_regs
